// ### hdl/burst_window.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_ccr_params.svh"
module burst_window
(
    input  wire logic                   clk_sys,     // System clock
    input  wire logic                   srst,        // Synchronous reset
    input  wire timer_ccr_pkg::field5_t burst_len,   // Length field, transfers minus one
    input  wire logic                   trigger,     // DMA triggering event
    input  wire logic                   win_access,  // Access to the window this cycle
    output var  timer_ccr_pkg::field5_t offset,      // Word offset from base
    output logic                        dma_req      // Request towards DMA
);
    import timer_ccr_pkg::*;

    burst_state_t state_reg;
    field5_t      offset_reg;
    logic         gap_reg;
    logic         last_access;

    assign last_access = win_access && (offset_reg == burst_len);    // R7

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            offset_reg <= 5'h00;
        else if (last_access)
            offset_reg <= 5'h00;                                // R13
        else if (win_access)
            offset_reg <= offset_reg + 5'h01;                   // R9
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state_reg <= BURST_IDLE;
        else
        begin
            case (state_reg)
                BURST_IDLE: if (trigger) state_reg <= BURST_BUSY;
                BURST_BUSY: if (last_access) state_reg <= BURST_IDLE;
                default:    state_reg <= BURST_IDLE;
            endcase
        end
    end

    // One idle cycle after each access so each request stands alone
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            gap_reg <= 1'b0;
        else
            gap_reg <= win_access;
    end

    assign dma_req = (state_reg == BURST_BUSY) && !gap_reg;               // R12
    assign offset  = offset_reg;
endmodule : burst_window
`default_nettype wire

// ### hdl/ccr_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ccr_chan_if;
    import timer_ccr_pkg::*;

    logic    wr_en;
    word16_t wdata;
    logic    preload_en;
    logic    input_mode;
    logic    update_evt;
    logic    capture_evt;
    word16_t counter;
    word16_t value;
    logic    match;
    logic    match_evt;

    modport owner
    (
        output wr_en, wdata, preload_en, input_mode, update_evt, capture_evt, counter,
        input  value, match, match_evt
    );

    modport chan
    (
        input  wr_en, wdata, preload_en, input_mode, update_evt, capture_evt, counter,
        output value, match, match_evt
    );
endinterface : ccr_chan_if
`default_nettype wire

// ### hdl/ccr_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_ccr_params.svh"
module ccr_channel
(
    input  wire logic clk_sys,   // System clock
    input  wire logic srst,      // Synchronous reset
    ccr_chan_if.chan  bus        // Channel control and status
);
    import timer_ccr_pkg::*;

    word16_t preload_reg;
    word16_t active_reg;
    logic    match_reg;
    logic    match_next;

    // Preload register doubles as the capture register in input mode
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            preload_reg <= `CCR_RESET;
        else if (bus.input_mode && bus.capture_evt)
            preload_reg <= bus.counter;                        // R5
        else if (!bus.input_mode && bus.wr_en)
            preload_reg <= bus.wdata;                          // R6
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            active_reg <= `CCR_RESET;
        else if (!bus.input_mode && bus.wr_en && !bus.preload_en)
            active_reg <= bus.wdata;                           // R2
        else if (!bus.input_mode && bus.preload_en && bus.update_evt)
            active_reg <= preload_reg;                         // R3
    end

    assign match_next = !bus.input_mode && (bus.counter == active_reg);   // R1

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            match_reg <= 1'b0;
        else
            match_reg <= match_next;
    end

    assign bus.value     = preload_reg;
    assign bus.match     = match_reg;
    assign bus.match_evt = match_next && !match_reg;
endmodule : ccr_channel
`default_nettype wire

// ### hdl/timer_ccr_params.svh
// Overview of operation
// R1 - Output channel compares its active value with the counter to drive its compare output.
// R2 - Preload off: a software write goes straight into the active compare register.
// R3 - Preload on: a write waits in preload until an update event moves it.
// R4 - Channels 1 and 2 preload from mode register A; 3 and 4 from B.
// R5 - Input channel value holds the counter latched at its last capture event.
// R6 - Value register ignores writes in input mode; read-write in output mode.
// R7 - Burst length field bits 12:8 gives value plus one window accesses.
// R8 - Base field bits 4:0 selects the first register reached through the window.
// R9 - First window access reaches base; each next one reaches one word further.
// R10 - Software writes reserved burst control bits 15:13 and 7:5 with reset value.
// R11 - Window access maps to control one address plus four times base field.
// R12 - Trigger issues DMA requests; DMA makes full programmed transfer count, one each.
// R13 - After the final burst access the window offset returns to zero.
`ifndef TIMER_CCR_PARAMS_SVH
`define TIMER_CCR_PARAMS_SVH

`define CTRL_ONE_ADDR    8'h00
`define IRQ_MASK_ADDR    8'h0C
`define IRQ_STATUS_ADDR  8'h10
`define MODE_A_ADDR      8'h18
`define MODE_B_ADDR      8'h1C
`define CH1_VALUE_ADDR   8'h34
`define CH2_VALUE_ADDR   8'h38
`define CH3_VALUE_ADDR   8'h3C
`define CH4_VALUE_ADDR   8'h40
`define BURST_CTRL_ADDR  8'h48
`define WINDOW_ADDR      8'h4C

`define BURST_LEN_MSB    12
`define BURST_LEN_LSB    8
`define BURST_BASE_MSB   4
`define BURST_BASE_LSB   0

`define MODE_LO_SEL_LSB  0
`define MODE_LO_PRE_BIT  3
`define MODE_HI_SEL_LSB  8
`define MODE_HI_PRE_BIT  11
`define MODE_WMASK       16'h0B0B

`define CCR_RESET        16'h0000
`define BURST_RESET      16'h0000
`define MODE_RESET       16'h0000
`define IRQ_RESET        8'h00

`endif

// ### hdl/timer_ccr_pkg.sv
package timer_ccr_pkg;

    typedef logic [15:0] word16_t;
    typedef logic [4:0]  field5_t;

    typedef enum logic [0:0]
    {
        BURST_IDLE = 1'b0,
        BURST_BUSY = 1'b1
    } burst_state_t;

endpackage : timer_ccr_pkg

// ### hdl/timer_ccr_top.sv
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "timer_ccr_params.svh"
module timer_ccr_top
(
    input  wire logic                   clk_sys,          // System clock, 100 MHz
    input  wire logic                   srst,             // Synchronous reset, high
    input  wire logic [7:0]             reg_addr,         // Register byte address
    input  wire logic [31:0]            reg_wdata,        // Write data
    input  wire logic                   reg_wr,           // Write strobe
    input  wire logic                   reg_rd,           // Read strobe
    output logic [31:0]                 reg_rdata,        // Read data, cycle after strobe
    input  wire timer_ccr_pkg::word16_t counter_register, // Running timer counter
    input  wire logic                   update_event,     // Timer update event pulse
    input  wire logic                   dma_trigger,      // Event starting a burst
    output logic                        dma_req,          // DMA request level
    input  wire logic                   capture_in_ch1,   // Capture pin channel 1
    input  wire logic                   capture_in_ch2,   // Capture pin channel 2
    input  wire logic                   capture_in_ch3,   // Capture pin channel 3
    input  wire logic                   capture_in_ch4,   // Capture pin channel 4
    output logic                        compare_out_ch1,  // Compare match channel 1
    output logic                        compare_out_ch2,  // Compare match channel 2
    output logic                        compare_out_ch3,  // Compare match channel 3
    output logic                        compare_out_ch4,  // Compare match channel 4
    output logic                        irq               // Interrupt level
);
    import timer_ccr_pkg::*;

    localparam int CHANNELS = 4;

    // Channel index of a value register address, or 4 when none
    function automatic logic [2:0] chan_of(input logic [7:0] addr);
        case (addr)
            `CH1_VALUE_ADDR: chan_of = 3'd0;
            `CH2_VALUE_ADDR: chan_of = 3'd1;
            `CH3_VALUE_ADDR: chan_of = 3'd2;
            `CH4_VALUE_ADDR: chan_of = 3'd3;
            default:         chan_of = 3'd4;
        endcase
    endfunction : chan_of

    // Byte address reached through the window
    function automatic logic [7:0] window_target(input field5_t base, input field5_t offset);
        logic [5:0] word_index;
        word_index    = {1'b0, base} + {1'b0, offset};
        window_target = `CTRL_ONE_ADDR + {word_index, 2'b00};
    endfunction : window_target

    word16_t        mode_a_reg;
    word16_t        mode_b_reg;
    field5_t        burst_len_reg;
    field5_t        burst_base_reg;
    logic [7:0]     irq_status_reg;
    logic [7:0]     irq_status_next;
    logic [7:0]     irq_mask_reg;
    logic [31:0]    rdata_reg;
    logic [31:0]    rdata_next;

    logic [3:0]     cap_pins;
    logic [3:0]     cap_sync1_reg;
    logic [3:0]     cap_sync2_reg;
    logic [3:0]     cap_last_reg;
    logic [3:0]     cap_evt;
    logic [3:0]     chan_input;
    logic [3:0]     chan_preload;
    logic [3:0]     chan_match;
    logic [3:0]     chan_match_evt;
    word16_t        chan_value [CHANNELS];

    field5_t        win_offset;
    logic           win_access;
    logic [7:0]     eff_addr;
    logic [2:0]     eff_chan;
    logic           eff_wr;

    assign cap_pins = {capture_in_ch4, capture_in_ch3, capture_in_ch2, capture_in_ch1};

    // Two-flop synchroniser then edge detect on the second stage
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cap_sync1_reg <= 4'h0;
            cap_sync2_reg <= 4'h0;
            cap_last_reg  <= 4'h0;
        end
        else
        begin
            cap_sync1_reg <= cap_pins;
            cap_sync2_reg <= cap_sync1_reg;
            cap_last_reg  <= cap_sync2_reg;
        end
    end

    assign cap_evt = cap_sync2_reg & ~cap_last_reg;

    // Mode selection and preload enables per channel
    assign chan_input[0]   = mode_a_reg[`MODE_LO_SEL_LSB +: 2] != 2'b00;
    assign chan_input[1]   = mode_a_reg[`MODE_HI_SEL_LSB +: 2] != 2'b00;
    assign chan_input[2]   = mode_b_reg[`MODE_LO_SEL_LSB +: 2] != 2'b00;
    assign chan_input[3]   = mode_b_reg[`MODE_HI_SEL_LSB +: 2] != 2'b00;
    assign chan_preload[0] = mode_a_reg[`MODE_LO_PRE_BIT];    // R4
    assign chan_preload[1] = mode_a_reg[`MODE_HI_PRE_BIT];    // R4
    assign chan_preload[2] = mode_b_reg[`MODE_LO_PRE_BIT];    // R4
    assign chan_preload[3] = mode_b_reg[`MODE_HI_PRE_BIT];    // R4

    // Window accesses are redirected to the mapped register
    assign win_access = (reg_wr || reg_rd) && (reg_addr == `WINDOW_ADDR);
    assign eff_addr   = win_access ? window_target(burst_base_reg, win_offset)   // R11
                                   : reg_addr;
    assign eff_chan   = chan_of(eff_addr);
    assign eff_wr     = reg_wr;

    burst_window u_burst
    (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .burst_len  (burst_len_reg),
        .trigger    (dma_trigger),
        .win_access (win_access),
        .offset     (win_offset),
        .dma_req    (dma_req)
    );

    ccr_chan_if chan_bus [CHANNELS] ();

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_chan
            assign chan_bus[gi].wr_en       = eff_wr && (eff_chan == 3'(gi));
            assign chan_bus[gi].wdata       = reg_wdata[15:0];
            assign chan_bus[gi].preload_en  = chan_preload[gi];
            assign chan_bus[gi].input_mode  = chan_input[gi];
            assign chan_bus[gi].update_evt  = update_event;
            assign chan_bus[gi].capture_evt = cap_evt[gi];
            assign chan_bus[gi].counter     = counter_register;
            assign chan_value[gi]           = chan_bus[gi].value;
            assign chan_match[gi]           = chan_bus[gi].match;
            assign chan_match_evt[gi]       = chan_bus[gi].match_evt;

            ccr_channel u_chan
            (
                .clk_sys (clk_sys),
                .srst    (srst),
                .bus     (chan_bus[gi])
            );
        end
    endgenerate

    assign compare_out_ch1 = chan_match[0];
    assign compare_out_ch2 = chan_match[1];
    assign compare_out_ch3 = chan_match[2];
    assign compare_out_ch4 = chan_match[3];

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mode_a_reg <= `MODE_RESET;
            mode_b_reg <= `MODE_RESET;
        end
        else if (eff_wr && eff_addr == `MODE_A_ADDR)
            mode_a_reg <= reg_wdata[15:0] & `MODE_WMASK;
        else if (eff_wr && eff_addr == `MODE_B_ADDR)
            mode_b_reg <= reg_wdata[15:0] & `MODE_WMASK;
    end

    // Reserved bits are not stored and read as zero
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            burst_len_reg  <= 5'(`BURST_RESET >> `BURST_LEN_LSB);
            burst_base_reg <= 5'(`BURST_RESET >> `BURST_BASE_LSB);
        end
        else if (eff_wr && eff_addr == `BURST_CTRL_ADDR)
        begin
            burst_len_reg  <= reg_wdata[`BURST_LEN_MSB:`BURST_LEN_LSB];     // R7
            burst_base_reg <= reg_wdata[`BURST_BASE_MSB:`BURST_BASE_LSB];   // R8
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            irq_mask_reg <= `IRQ_RESET;
        else if (eff_wr && eff_addr == `IRQ_MASK_ADDR)
            irq_mask_reg <= reg_wdata[7:0];
    end

    // Write one clears; a new event in the same cycle wins
    always_comb
    begin
        irq_status_next = irq_status_reg;
        if (eff_wr && eff_addr == `IRQ_STATUS_ADDR)
            irq_status_next = irq_status_next & ~reg_wdata[7:0];
        irq_status_next = irq_status_next | {cap_evt & chan_input, chan_match_evt};
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            irq_status_reg <= `IRQ_RESET;
        else
            irq_status_reg <= irq_status_next;
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (reg_rd)
        begin
            case (eff_addr)
                `CH1_VALUE_ADDR:  rdata_next[15:0] = chan_value[0];
                `CH2_VALUE_ADDR:  rdata_next[15:0] = chan_value[1];
                `CH3_VALUE_ADDR:  rdata_next[15:0] = chan_value[2];
                `CH4_VALUE_ADDR:  rdata_next[15:0] = chan_value[3];
                `MODE_A_ADDR:     rdata_next[15:0] = mode_a_reg;
                `MODE_B_ADDR:     rdata_next[15:0] = mode_b_reg;
                `IRQ_MASK_ADDR:   rdata_next[7:0]  = irq_mask_reg;
                `IRQ_STATUS_ADDR: rdata_next[7:0]  = irq_status_reg;
                `BURST_CTRL_ADDR:
                begin
                    rdata_next[`BURST_LEN_MSB:`BURST_LEN_LSB]   = burst_len_reg;
                    rdata_next[`BURST_BASE_MSB:`BURST_BASE_LSB] = burst_base_reg;
                end
                default:          rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;
endmodule : timer_ccr_top
`default_nettype wire

// ### test/dma_model.sv
`timescale 1ns/100ps
`default_nettype none
module dma_model
(
    input  wire logic        clk_sys,   // System clock
    input  wire logic        srst,      // Synchronous reset
    input  wire logic        dma_req,   // Request from timer
    input  wire logic [31:0] reg_rdata, // Read data from timer
    input  wire logic        slow,      // Wait before each access
    output logic             dma_rd     // Window read strobe
);
    logic [15:0] data [0:15];
    logic [3:0]  cnt;
    logic        rd_q;
    logic [1:0]  wait_cnt;
    // One access per request, optionally delayed
    always_ff @(posedge clk_sys)
    begin
        if (srst || !dma_req || dma_rd)
        begin
            dma_rd   <= 1'b0;
            wait_cnt <= 2'd0;
        end
        else if (slow && wait_cnt != 2'd2)
            wait_cnt <= wait_cnt + 2'd1;
        else
            dma_rd <= 1'b1;
    end
    always_ff @(posedge clk_sys)
    begin
        rd_q <= dma_rd && !srst;
        if (srst)
            cnt <= 4'd0;
        else if (rd_q)
        begin
            data[cnt] <= reg_rdata[15:0];
            cnt       <= cnt + 4'd1;
        end
    end
endmodule : dma_model
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import timer_ccr_pkg::*;
    logic        clk_sys, srst, tb_wr, tb_rd, update_event, dma_trigger, slow;
    logic [7:0]  tb_addr;
    logic [31:0] tb_wdata, rdata;
    logic [3:0]  cap;
    word16_t     counter_register;
    word16_t     vals [0:3];
    wire  [31:0] reg_rdata;
    wire  [3:0]  cmp;
    wire         dma_req, dma_rd, irq;
    int          err_total, samples_checked, k;
    int          cycles = 0;
    logic [7:0]  ra [0:5] = '{8'h34, 8'h38, 8'h3C, 8'h40, 8'h48, 8'h44};
    word16_t     cfg [0:3] = '{16'h030D, 16'h010F, 16'h000C, 16'h0012};
    timer_ccr_top i_dut
    (
        .clk_sys, .srst, .reg_addr(dma_rd ? 8'h4C : tb_addr), .reg_wdata(tb_wdata),
        .reg_wr(tb_wr), .reg_rd(tb_rd | dma_rd), .reg_rdata, .counter_register,
        .update_event, .dma_trigger, .dma_req, .capture_in_ch1(cap[0]),
        .capture_in_ch2(cap[1]), .capture_in_ch3(cap[2]), .capture_in_ch4(cap[3]),
        .compare_out_ch1(cmp[0]), .compare_out_ch2(cmp[1]), .compare_out_ch3(cmp[2]),
        .compare_out_ch4(cmp[3]), .irq
    );
    dma_model i_dma (.clk_sys, .srst, .dma_req, .reg_rdata, .slow, .dma_rd);
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            finish_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        tb_addr  <= a;
        tb_wdata <= v;
        tb_wr    <= 1'b1;
        @(posedge clk_sys);
        tb_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        tb_addr <= a;
        tb_rd   <= 1'b1;
        @(posedge clk_sys);
        tb_rd <= 1'b0;
        #1 rdata = reg_rdata;
    endtask : rd
    function automatic logic [31:0] expect_at(input logic [4:0] b, input word16_t c);
        if (b >= 5'h0D && b <= 5'h10)
            return {16'h0000, vals[b - 5'h0D]};
        return (b == 5'h12) ? {16'h0000, c} : 32'h0;
    endfunction : expect_at
    task t_reset_values;
        for (int i = 0; i < 6; i++)
        begin
            rd(ra[i]);
            check(rdata, 32'h0);
        end
    endtask : t_reset_values
    task t_capture;
        wr(8'h18, 32'h0101);
        wr(8'h1C, 32'h0101);
        rd(8'h1C);
        check(rdata, 32'h0101);
        counter_register <= 16'h0ABC;
        cap              <= 4'hF;
        tick(6);
        counter_register <= 16'h0123;
        check(irq, 1'b0);
        for (int ch = 0; ch < 4; ch++)
        begin
            rd(ra[ch]);
            check(rdata, 32'h0ABC);
            wr(ra[ch], 32'h5555);
            rd(ra[ch]);
            check(rdata, 32'h0ABC);
            vals[ch] = 16'h0ABC;
        end
        wr(8'h0C, 32'hF0);
        check(irq, 1'b1);
        // Matches at counter zero after reset, then four captures
        rd(8'h10);
        check(rdata, 32'hFF);
        wr(8'h10, 32'hF0);
        check(irq, 1'b0);
        cap <= 4'h0;
        wr(8'h18, 32'h0);
        wr(8'h1C, 32'h0);
    endtask : t_capture
    task t_direct;
        for (int ch = 0; ch < 4; ch++)
        begin
            vals[ch] = 16'h1000 * 16'(ch + 1) + 16'h00A5;
            wr(ra[ch], {16'h0000, vals[ch]});
            rd(ra[ch]);
            check(rdata, {16'h0000, vals[ch]});
            counter_register <= vals[ch];
            tick(3);
            check(cmp, 32'h1 << ch);
        end
        wr(8'h0C, 32'h0F);
        check(irq, 1'b1);
        wr(8'h10, 32'h0F);
        check(irq, 1'b0);
    endtask : t_direct
    task t_preload;
        wr(8'h18, 32'h0008);
        wr(8'h1C, 32'h0800);
        wr(8'h34, 32'h1111);
        wr(8'h40, 32'h4444);
        counter_register <= 16'h1111;
        tick(3);
        check(cmp, 32'h0);
        update_event <= 1'b1;
        @(posedge clk_sys);
        update_event <= 1'b0;
        tick(2);
        check(cmp, 32'h1);
        counter_register <= 16'h4444;
        tick(3);
        check(cmp, 32'h8);
        vals[0] = 16'h1111;
        vals[3] = 16'h4444;
    endtask : t_preload
    task t_burst;
        k = 0;
        for (int e = 0; e < 4; e++)
        begin
            wr(8'h48, {16'h0000, cfg[e]});
            slow        <= e[0];
            dma_trigger <= 1'b1;
            @(posedge clk_sys);
            dma_trigger <= 1'b0;
            for (int w = 0; w < 300 && i_dma.cnt != k + cfg[e][12:8] + 1; w++)
                @(posedge clk_sys);
            k = k + cfg[e][12:8] + 1;
            tick(6);
            check(dma_req, 1'b0);
            check(i_dma.cnt, k[3:0]);
            for (int j = 0; j <= cfg[e][12:8]; j++)
                check(i_dma.data[k - cfg[e][12:8] - 1 + j],
                      expect_at(cfg[e][4:0] + 5'(j), cfg[e]));
        end
    endtask : t_burst
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    initial
    begin
        srst = 1'b1;
        {tb_wr, tb_rd, update_event, dma_trigger, slow} = 5'b0;
        {tb_addr, tb_wdata, cap, counter_register} = '0;
        err_total = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset_values();
        t_capture();
        t_direct();
        t_preload();
        t_burst();
        finish_test();
    end
endmodule : testbench
`default_nettype wire

// ### test/timer_ccr_sva.sv
`timescale 1ns/100ps
`default_nettype none
module timer_ccr_sva
(
    input  wire logic                   clk_sys,          // System clock
    input  wire logic                   srst,             // Synchronous reset
    input  wire logic [7:0]             reg_addr,         // Register address
    input  wire logic [31:0]            reg_wdata,        // Write data
    input  wire logic                   reg_wr,           // Write strobe
    input  wire logic                   reg_rd,           // Read strobe
    input  wire logic [31:0]            reg_rdata,        // Read data
    input  wire timer_ccr_pkg::word16_t counter_register, // Running counter
    input  wire logic                   update_event,     // Update pulse
    input  wire logic                   dma_trigger,      // Burst start
    input  wire logic                   dma_req,          // DMA request
    input  wire logic                   compare_out_ch1   // Compare output 1
);
    import timer_ccr_pkg::*;
    logic       win;
    logic       in1_reg;
    logic [4:0] off_reg;
    word16_t    bc_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    assign win = (reg_rd || reg_wr) && reg_addr == 8'h4C;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            bc_reg <= 16'h0000;
        else if (reg_wr && reg_addr == 8'h48)
            bc_reg <= reg_wdata[15:0] & 16'h1F1F;
    end
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            in1_reg <= 1'b0;
        else if (reg_wr && reg_addr == 8'h18)
            in1_reg <= reg_wdata[1:0] != 2'b00;
    end
    // Mirror of the window offset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            off_reg <= 5'h00;
        else if (win)
            off_reg <= (off_reg == bc_reg[12:8]) ? 5'h00 : off_reg + 5'h01;
    end
    cmp_hold_a: assert property ($stable(counter_register) && !$past(update_event)
        && !$past(reg_wr) && !$past(srst) |=> $stable(compare_out_ch1))
        else $error("compare output changed without cause");
    in_mode_a: assert property ($past(in1_reg) |-> !compare_out_ch1)
        else $error("compare output high in input mode");
    req_start_a: assert property ($rose(dma_req) |-> $past(dma_trigger) || $past(win, 2))
        else $error("request rose without trigger or access");
    req_gap_a: assert property (win && dma_req |=> !dma_req)
        else $error("request not dropped after access");
    burst_next_a: assert property (win && dma_req && off_reg != bc_reg[12:8]
        |=> !dma_req ##1 dma_req)
        else $error("burst stopped early");
    burst_end_a: assert property (win && dma_req && off_reg == bc_reg[12:8]
        |=> !dma_req [*2])
        else $error("burst ran past its length");
    bctrl_read_a: assert property (reg_rd && reg_addr == 8'h48
        |=> reg_rdata == {16'h0000, bc_reg})
        else $error("burst control read back wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule : timer_ccr_sva
bind timer_ccr_top timer_ccr_sva i_sva
(
    .clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .counter_register, .update_event, .dma_trigger, .dma_req, .compare_out_ch1
);
`default_nettype wire
